//--- hw/tsc_core.v
// Single-wire thermometer slave: scratchpad, nonvolatile copy, identity code and CRC
// How it works
// - Supply query after skip: parasite device pulls read slot low, else releases.
// - Identity: family byte low, 48-bit serial, top byte CRC of 56 bits.
// - Bytes 0 and 1 show temperature result and ignore writes.
// - Bytes 2-4 hold alarm limits and config; bytes 5-7 are write protected.
// - Byte 8 is read-only CRC over bytes 0 to 7.
// - Scratchpad write fills bytes 2, 3, 4 starting at bit 0 of byte 2.
// - Scratchpad read sends from bit 0 of byte 0 onward in order.
// - Store copies alarm limits and config into nonvolatile storage.
// - At power-up nonvolatile values load into the scratchpad.
// - Reload refills scratchpad; read slots show 0 while busy, 1 when done.
// - Config bits 6:5 pick 9 to 12 bit resolution, default 12.
// - Config bit 7 reads 0, bits 4:0 read 1, writes never change them.
// - CRCs use x^8+x^5+x^4+1, start at zero, LSB first.
// - A CRC mismatch never blocks or aborts any command.
// - Scratchpad CRC follows every change of scratchpad contents.
// - Every byte travels least significant bit first.
// - Bus low longer than 480 us resets the slave.
// - Bus idles high; idle periods of any length are tolerated.
// - Temperature bytes hold +85 degrees until first conversion.
`timescale 1ns/1ps
`include "tsc_regs.vh"
module tsc_core #(
  parameter [7:0] FAMILY_CODE = 8'h5a,    // Arbitrary value
  parameter [47:0] SERIAL = 48'h0123456789ab, // Arbitrary value
  parameter [23:0] SLOT_CYC = `T_SLOT_US * `CLK_MHZ,
  parameter [23:0] RESET_CYC = `T_RESET_US * `CLK_MHZ,
  parameter [23:0] PWAIT_CYC = `T_PRES_WAIT_US * `CLK_MHZ,
  parameter [23:0] PRES_CYC = `T_PRES_LEN_US * `CLK_MHZ,
  parameter [23:0] NVWR_CYC = `T_NVWR_MS * `US_PER_MS * `CLK_MHZ,
  parameter [23:0] RELOAD_CYC = `T_RELOAD_US * `CLK_MHZ,
  parameter FIFO_DEPTH = 32
) (
  // Clock, reset, enable
  input wire CLK,
  input wire RST_B,
  input wire CE,
  // Data line, open drain
  input wire DQ_IN,
  output reg DQ_OUT,
  output reg DQ_OE,
  // Supply sense pin, high when supply pin is grounded
  input wire SUPPLY_PARASITE,
  // Sensor core
  input wire TEMP_DONE,
  input wire [15:0] TEMP_DATA,
  output reg CONV_START,
  output reg [1:0] CONV_RES
);
  localparam [2:0] B_IDLE = 3'h0, B_LOW = 3'h1, B_HIGHW = 3'h2;
  localparam [2:0] B_PWAIT = 3'h3, B_PRES = 3'h4;
  localparam [2:0] H_ROM = 3'h0, H_FUNC = 3'h1, H_WR = 3'h2, H_TX = 3'h3, H_HOLD = 3'h4;
  localparam [1:0] K_ROM = 2'h0, K_SP = 2'h1, K_CONV = 2'h2, K_STAT = 2'h3;

  // Synchronisers and bit engine
  reg dq_m, dq_s, dq_prev, par_m, parasite;
  reg [2:0] b_st;
  reg [23:0] b_cnt;
  reg rst_seen, bus_rst, rx_pend;
  reg [7:0] rx_sr, rx_byte;
  reg [2:0] rx_cnt;
  reg [6:0] bit_idx;

  // Command handler and storage
  reg [2:0] h_st;
  reg [1:0] kind, res, nv_res;
  reg [3:0] wr_off;
  reg [15:0] temp;
  reg [7:0] upper, lower, nv_upper, nv_lower;
  reg boot, conv_busy, nv_busy, nv_store, ask_supply;
  reg [23:0] nv_cnt;

  wire fifo_ready, cmd_valid, cmd_take, tx_mode, fall;
  wire [7:0] cmd, cfg_byte, sp_crc, id_crc;
  wire [63:0] sp_data, id_code;
  wire [71:0] sp_vec;
  reg tx_bit;

  function [7:0] crc8;
    input [63:0] d;
    input [6:0] n;
    integer i;
    reg [7:0] c;
    reg fb;
    begin
      c = `CRC_INIT;
      for (i = 0; i < 64; i = i + 1)
      begin
        fb = c[0] ^ d[i];
        if (i < n)
          c = fb ? ((c >> 1) ^ `CRC_POLY_REV) : (c >> 1);
      end
      crc8 = c;
    end
  endfunction

  assign cfg_byte = {`CFG_FIXED_TOP, res, `CFG_FIXED_LOW};
  assign sp_data = {`SP_RESERVED, cfg_byte, lower, upper, temp};
  assign sp_crc = crc8(sp_data, `SP_DATA_BITS);
  assign sp_vec = {sp_crc, sp_data};
  assign id_crc = crc8({8'h00, SERIAL, FAMILY_CODE}, `ID_DATA_BITS);
  assign id_code = {id_crc, SERIAL, FAMILY_CODE};
  assign tx_mode = (h_st == H_TX);
  assign fall = dq_prev && !dq_s;
  // Handler stalls while nonvolatile work runs, so received bytes back up in the FIFO
  assign cmd_take = cmd_valid && !nv_busy;

  always @*
  begin
    case (kind)
      K_ROM: tx_bit = (bit_idx < `ID_BITS) ? id_code[bit_idx[5:0]] : 1'b1;
      K_SP: tx_bit = (bit_idx < `SP_BITS) ? sp_vec[bit_idx] : 1'b1;
      K_CONV: tx_bit = !conv_busy;
      // Store and reload answer 1 when done whatever the supply; only the query reports it
      default: tx_bit = nv_busy ? 1'b0 : !(ask_supply && parasite);
    endcase
  end

  tsc_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .AW(5)) u_rx_fifo (
    .clk(CLK), .rst_b(RST_B),
    .en(CE), .flush(bus_rst),
    .in_valid(rx_pend), .in_ready(fifo_ready),
    .in_data(rx_byte), .out_valid(cmd_valid),
    .out_ready(cmd_take), .out_data(cmd)
  );

  // Slot engine and pin synchronisers; the idle and high-wait states never time out, slot and presence-wait counts still end with the line high
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dq_m <= 1'b1;
      dq_s <= 1'b1;
      dq_prev <= 1'b1;
      par_m <= 1'b0;
      parasite <= 1'b0;
      b_st <= B_IDLE;
      b_cnt <= 24'h000000;
      rst_seen <= 1'b0;
      bus_rst <= 1'b0;
      rx_sr <= 8'h00;
      rx_cnt <= 3'h0;
      rx_pend <= 1'b0;
      rx_byte <= 8'h00;
      bit_idx <= 7'h00;
      DQ_OUT <= 1'b0;
      DQ_OE <= 1'b0;
    end
    else if (CE)
    begin
      dq_m <= DQ_IN;
      dq_s <= dq_m;
      dq_prev <= dq_s;
      par_m <= SUPPLY_PARASITE;
      parasite <= par_m;
      DQ_OUT <= 1'b0;
      bus_rst <= 1'b0;
      if (rx_pend && fifo_ready)
        rx_pend <= 1'b0;
      if (!tx_mode)
        bit_idx <= 7'h00;
      case (b_st)
        B_IDLE:
        begin
          b_cnt <= 24'h000000;
          if (fall)
          begin
            b_st <= B_LOW;
            DQ_OE <= tx_mode && !tx_bit;
          end
        end
        B_LOW:
        begin
          b_cnt <= b_cnt + 24'h000001;
          if (b_cnt == SLOT_CYC)
          begin
            DQ_OE <= 1'b0;
            b_st <= B_HIGHW;
            if (tx_mode)
              bit_idx <= bit_idx + 7'h01;
            else
            begin
              rx_sr <= {dq_s, rx_sr[7:1]};
              rx_cnt <= rx_cnt + 3'h1;
              if (rx_cnt == 3'h7)
              begin
                rx_pend <= 1'b1;
                rx_byte <= {dq_s, rx_sr[7:1]};
              end
            end
          end
        end
        B_HIGHW:
        begin
          b_cnt <= b_cnt + 24'h000001;
          if (dq_s)
          begin
            b_cnt <= 24'h000000;
            b_st <= rst_seen ? B_PWAIT : B_IDLE;
          end
          else if (b_cnt == RESET_CYC)
          begin
            rst_seen <= 1'b1;
            bus_rst <= 1'b1;
            rx_cnt <= 3'h0;
            rx_pend <= 1'b0;
          end
        end
        B_PWAIT:
        begin
          b_cnt <= b_cnt + 24'h000001;
          if (b_cnt == PWAIT_CYC)
          begin
            b_cnt <= 24'h000000;
            DQ_OE <= 1'b1;
            b_st <= B_PRES;
          end
        end
        B_PRES:
        begin
          b_cnt <= b_cnt + 24'h000001;
          if (b_cnt == PRES_CYC)
          begin
            DQ_OE <= 1'b0;
            rst_seen <= 1'b0;
            b_st <= B_HIGHW;
          end
        end
        default:
        begin
          DQ_OE <= 1'b0;
          b_st <= B_IDLE;
        end
      endcase
    end
  end

  // Command handler, scratchpad and nonvolatile copy; no CRC check gates any step
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      h_st <= H_ROM;
      kind <= K_ROM;
      wr_off <= `SP_UPPER_ALARM;
      temp <= `TEMP_POR;
      upper <= `NV_UPPER_DEF;
      lower <= `NV_LOWER_DEF;
      res <= `NV_RES_DEF;
      nv_upper <= `NV_UPPER_DEF;
      nv_lower <= `NV_LOWER_DEF;
      nv_res <= `NV_RES_DEF;
      boot <= 1'b1;
      conv_busy <= 1'b0;
      nv_busy <= 1'b0;
      nv_store <= 1'b0;
      ask_supply <= 1'b0;
      nv_cnt <= 24'h000000;
      CONV_START <= 1'b0;
      CONV_RES <= `NV_RES_DEF;
    end
    else if (CE)
    begin
      CONV_START <= 1'b0;
      CONV_RES <= res;
      if (boot)
      begin
        boot <= 1'b0;
        upper <= nv_upper;
        lower <= nv_lower;
        res <= nv_res;
      end
      if (TEMP_DONE)
      begin
        temp <= TEMP_DATA;
        conv_busy <= 1'b0;
      end
      if (nv_busy)
      begin
        nv_cnt <= nv_cnt + 24'h000001;
        if (nv_cnt == (nv_store ? NVWR_CYC : RELOAD_CYC))
        begin
          nv_busy <= 1'b0;
          if (nv_store)
          begin
            nv_upper <= upper;
            nv_lower <= lower;
            nv_res <= res;
          end
          else
          begin
            upper <= nv_upper;
            lower <= nv_lower;
            res <= nv_res;
          end
        end
      end
      if (bus_rst)
        h_st <= H_ROM;
      else if (cmd_take)
      begin
        case (h_st)
          H_ROM:
          begin
            if (cmd == `CMD_SKIP)
              h_st <= H_FUNC;
            else if (cmd == `CMD_READ_ID)
            begin
              kind <= K_ROM;
              h_st <= H_TX;
            end
            else
              h_st <= H_HOLD;
          end
          H_FUNC:
          begin
            h_st <= H_TX;
            wr_off <= `SP_UPPER_ALARM;
            ask_supply <= (cmd == `CMD_SUPPLY);
            if (cmd == `CMD_CONVERT)
            begin
              kind <= K_CONV;
              CONV_START <= 1'b1;
              conv_busy <= 1'b1;
            end
            else if (cmd == `CMD_WRITE_SP)
              h_st <= H_WR;
            else if (cmd == `CMD_READ_SP)
              kind <= K_SP;
            else if (cmd == `CMD_STORE || cmd == `CMD_RELOAD)
            begin
              kind <= K_STAT;
              nv_busy <= 1'b1;
              nv_store <= (cmd == `CMD_STORE);
              nv_cnt <= 24'h000000;
            end
            else if (cmd == `CMD_SUPPLY)
              kind <= K_STAT;
            else
              h_st <= H_HOLD;
          end
          H_WR:
          begin
            wr_off <= wr_off + 4'h1;
            if (wr_off == `SP_UPPER_ALARM)
              upper <= cmd;
            else if (wr_off == `SP_LOWER_ALARM)
              lower <= cmd;
            else if (wr_off == `SP_CONFIG)
            begin
              res <= cmd[`CFG_RES_HI:`CFG_RES_LO];
              h_st <= H_HOLD;
            end
          end
          default:
            h_st <= h_st;
        endcase
      end
    end
  end
endmodule // tsc_core

//--- hw/tsc_regs.vh
// Constants of the thermometer scratchpad, identity code and single-wire slave
`ifndef TSC_REGS_VH
`define TSC_REGS_VH

// Scratchpad byte offsets
`define SP_TEMP_LO 4'h0
`define SP_TEMP_HI 4'h1
`define SP_UPPER_ALARM 4'h2
`define SP_LOWER_ALARM 4'h3
`define SP_CONFIG 4'h4
`define SP_CHECKSUM 4'h8

// Configuration byte layout
`define CFG_RES_HI 6
`define CFG_RES_LO 5
`define CFG_FIXED_TOP 1'h0
`define CFG_FIXED_LOW 5'h1f

// Reset and default values
`define TEMP_POR 16'h0550
`define NV_UPPER_DEF 8'h00
`define NV_LOWER_DEF 8'h00
`define NV_RES_DEF 2'h3
`define SP_RESERVED 24'h000000

// CRC-8, x^8+x^5+x^4+1 shifted LSB first
`define CRC_POLY_REV 8'h8c
`define CRC_INIT 8'h00
`define ID_BITS 7'h40
`define ID_DATA_BITS 7'h38
`define SP_BITS 7'h48
`define SP_DATA_BITS 7'h40

// Command codes
`define CMD_SKIP 8'hcc
`define CMD_READ_ID 8'h33
`define CMD_CONVERT 8'h44
`define CMD_WRITE_SP 8'h4e
`define CMD_READ_SP 8'hbe
`define CMD_STORE 8'h48
`define CMD_RELOAD 8'hb8
`define CMD_SUPPLY 8'hb4

// Timing, in the unit named; sized to the 24-bit cycle counters so products stay 24 bits
`define CLK_MHZ 24'h0000fa
`define US_PER_MS 24'h0003e8
`define T_SLOT_US 24'h00001e
`define T_RESET_US 24'h0001e0
`define T_PRES_WAIT_US 24'h00001e
`define T_PRES_LEN_US 24'h000078
`define T_NVWR_MS 24'h00000a
`define T_RELOAD_US 24'h000002

`endif

//--- hw/tsc_fifo.v
// Synchronous flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tsc_fifo #(
  parameter W = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and control
  input wire clk,
  input wire rst_b,
  input wire en,
  input wire flush,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk)
  begin
    if (en && push)
      mem[wr_ptr] <= in_data;
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else if (en)
    begin
      if (flush)
      begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
      end
      else
      begin
        if (push)
          wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
        if (pop)
          rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
        if (push && !pop)
          count <= count + 1'b1;
        else if (pop && !push)
          count <= count - 1'b1;
      end
    end
  end
endmodule // tsc_fifo

//--- sim/tsc_master.sv
// Behavioural single-wire bus master for the thermometer slave
`timescale 1ns/1ps
module tsc_master (
  // Clock
  input wire clk,
  // Line
  input wire dev_oe,
  output wire line
);
  reg pull = 1'b0;
  // Pullup wins unless some party pulls low
  assign line = !(pull | dev_oe);
  task slot(input reg b, output reg r);
    begin
      @(posedge clk) #1 pull = 1'b1;
      repeat (2) @(posedge clk);
      #1 pull = !b;
      repeat (10) @(posedge clk);
      #1 r = line;
      repeat (24) @(posedge clk);
      #1 pull = 1'b0;
      repeat (6) @(posedge clk);
      #1;
    end
  endtask
  task bus_reset(output reg pres);
    begin
      @(posedge clk) #1 pull = 1'b1;
      repeat (250) @(posedge clk);
      #1 pull = 1'b0;
      repeat (45) @(posedge clk);
      #1 pres = !line;
      repeat (60) @(posedge clk);
      #1;
    end
  endtask
  task wr(input [7:0] d);
    integer i;
    reg r;
    begin
      for (i = 0; i < 8; i = i + 1)
        slot(d[i], r);
    end
  endtask
  task rd(output [7:0] d);
    integer i;
    reg r;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        slot(1'b1, r);
        d[i] = r;
      end
    end
  endtask
  // Stands in for the strong pullup: line released, no traffic at all
  task hold_high(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
endmodule // tsc_master

//--- sim/tsc_core_chk.sv
// Assertion checker for the thermometer slave ports
`timescale 1ns/1ps
module tsc_core_chk #(
  parameter [23:0] PRES_CYC = 24'd40,
  parameter [23:0] RELOAD_CYC = 24'd500
) (
  // Clock and reset
  input wire CLK,
  input wire RST_B,
  // Data line
  input wire DQ_IN,
  input wire DQ_OUT,
  input wire DQ_OE,
  // Sensor core
  input wire [1:0] CONV_RES
);
  reg [11:0] high_cnt;
  reg [7:0] low_cnt;
  reg [23:0] oe_cnt;
  // Saturating high and low run lengths, so long idle spans never wrap
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      high_cnt <= 12'h000;
      low_cnt <= 8'h00;
      oe_cnt <= 24'h000000;
    end
    else
    begin
      high_cnt <= DQ_IN ? high_cnt + {11'h000, high_cnt != 12'hfff} : 12'h000;
      low_cnt <= DQ_IN ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
      oe_cnt <= DQ_OE ? oe_cnt + 24'h000001 : 24'h000000;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_low_only;
    DQ_OUT == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("data output not low");
  property p_oe_len;
    oe_cnt <= PRES_CYC + 24'd1;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("line held too long");
  property p_long_low;
    low_cnt > 8'd100 |-> !DQ_OE;
  endproperty
  a_long_low: assert property (p_long_low)
    else $error("pull during bus reset");
  property p_oe_cause;
    $rose(DQ_OE) |-> high_cnt < 8'd40;
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("pull on idle line");
  property p_read_hold;
    $rose(DQ_OE) && high_cnt < 8'd8 |-> DQ_OE [*8];
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read slot pull too short");
  property p_pres_hold;
    $rose(DQ_OE) && high_cnt >= 8'd8 |-> DQ_OE [*8];
  endproperty
  a_pres_hold: assert property (p_pres_hold)
    else $error("presence too short");
  property p_res_def;
    $rose(RST_B) |-> CONV_RES == 2'h3;
  endproperty
  a_res_def: assert property (p_res_def)
    else $error("resolution default wrong");
  property p_res_cause;
    // A reload may finish its copy a full reload time into an idle span
    !$stable(CONV_RES) |-> {12'h000, high_cnt} < RELOAD_CYC + 24'h00003c;
  endproperty
  a_res_cause: assert property (p_res_cause)
    else $error("resolution changed alone");
endmodule // tsc_core_chk
bind tsc_core tsc_core_chk #(.PRES_CYC(PRES_CYC), .RELOAD_CYC(RELOAD_CYC)) u_chk (
  .CLK(CLK), .RST_B(RST_B), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
  .CONV_RES(CONV_RES));

//--- sim/tb.sv
// Self-checking bench for the thermometer slave
`timescale 1ns/1ps
module tb;
  localparam [7:0] FAM = 8'h5a; // Design default identity, value arbitrary
  localparam [47:0] SER = 48'h0123456789ab; // Design default identity, value arbitrary
  reg CLK = 1'b0;
  reg RST_B = 1'b0;
  reg CE = 1'b1;
  reg SUPPLY_PARASITE = 1'b0;
  reg TEMP_DONE = 1'b0;
  reg [15:0] TEMP_DATA = 16'h0000;
  wire DQ_IN;
  wire DQ_OUT;
  wire DQ_OE;
  wire CONV_START;
  wire [1:0] CONV_RES;
  integer num_errors = 0;
  integer cmp_count = 0;
  integer r;
  reg [7:0] sp [0:8];
  reg [7:0] b;
  reg pres;
  reg bitv;
  always #2 CLK = ~CLK;
  tsc_core #(.SLOT_CYC(24'h000014), .RESET_CYC(24'h0000c8), .PWAIT_CYC(24'h000014),
    .PRES_CYC(24'h000028), .NVWR_CYC(24'h000032)) u_dut (
    .CLK(CLK), .RST_B(RST_B), .CE(CE), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
    .SUPPLY_PARASITE(SUPPLY_PARASITE), .TEMP_DONE(TEMP_DONE), .TEMP_DATA(TEMP_DATA),
    .CONV_START(CONV_START), .CONV_RES(CONV_RES));
  tsc_master u_mst (.clk(CLK), .dev_oe(DQ_OE), .line(DQ_IN));
  task check(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  function [7:0] crc8(input [7:0] c, input [7:0] d);
    integer i;
    reg fb;
    begin
      crc8 = c;
      for (i = 0; i < 8; i = i + 1)
      begin
        fb = crc8[0] ^ d[i];
        crc8 = (crc8 >> 1) ^ (fb ? 8'h8c : 8'h00);
      end
    end
  endfunction
  task start(input [7:0] rom, input [7:0] fn);
    begin
      u_mst.bus_reset(pres);
      check({7'h00, pres}, 8'h01);
      u_mst.wr(rom);
      u_mst.wr(fn);
    end
  endtask
  task sp_expect(input [39:0] e);
    integer k;
    reg [7:0] c;
    reg [7:0] x;
    begin
      start(8'hcc, 8'hbe);
      for (k = 0; k < 9; k = k + 1)
        u_mst.rd(sp[k]);
      c = 8'h00;
      for (k = 0; k < 8; k = k + 1)
      begin
        x = (k < 5) ? e[8*k +: 8] : 8'h00;
        c = crc8(c, x);
        check(sp[k], x);
      end
      check(sp[8], c);
    end
  endtask
  task t_power_up;
    begin
      check({6'h00, CONV_RES}, 8'h03);
      sp_expect({8'h7f, 8'h00, 8'h00, 8'h05, 8'h50});
    end
  endtask
  task t_resolution;
    begin
      for (r = 0; r < 4; r = r + 1)
      begin
        start(8'hcc, 8'h4e);
        u_mst.wr(8'ha5);
        u_mst.wr(8'h3c);
        u_mst.wr({1'b1, r[1:0], 5'h00});
        sp_expect({1'b0, r[1:0], 5'h1f, 8'h3c, 8'ha5, 8'h05, 8'h50});
        check({6'h00, CONV_RES}, {6'h00, r[1:0]});
      end
    end
  endtask
  task t_identity;
    reg [7:0] c;
    reg [63:0] id;
    begin
      id = {8'h00, SER, FAM};
      c = 8'h00;
      u_mst.bus_reset(pres);
      u_mst.wr(8'h33);
      for (r = 0; r < 8; r = r + 1)
      begin
        u_mst.rd(b);
        check(b, (r < 7) ? id[8*r +: 8] : c);
        c = crc8(c, b);
      end
      check(c, 8'h00);
    end
  endtask
  task t_supply;
    begin
      for (r = 0; r < 2; r = r + 1)
      begin
        SUPPLY_PARASITE = r[0];
        start(8'hcc, 8'hb4);
        u_mst.slot(1'b1, bitv);
        check({7'h00, bitv}, {7'h00, ~r[0]});
      end
      SUPPLY_PARASITE = 1'b0;
    end
  endtask
  task t_convert;
    begin
      start(8'hcc, 8'h44);
      u_mst.hold_high(20);
      TEMP_DATA = 16'hfe6f;
      TEMP_DONE = 1'b1;
      @(posedge CLK) #1 TEMP_DONE = 1'b0;
      sp_expect({8'h7f, 8'h3c, 8'ha5, 8'hfe, 8'h6f});
    end
  endtask
  task t_nvm;
    begin
      start(8'hcc, 8'h48);
      u_mst.slot(1'b1, bitv);
      check({7'h00, bitv}, 8'h00);
      u_mst.hold_high(100);
      start(8'hcc, 8'h4e);
      u_mst.wr(8'h11);
      u_mst.wr(8'h22);
      u_mst.wr(8'h00);
      start(8'hcc, 8'hb8);
      u_mst.slot(1'b1, bitv);
      check({7'h00, bitv}, 8'h00);
      u_mst.hold_high(480);
      u_mst.slot(1'b1, bitv);
      check({7'h00, bitv}, 8'h01);
      sp_expect({8'h7f, 8'h3c, 8'ha5, 8'hfe, 8'h6f});
    end
  endtask
  // With the enable low the slave must not see a bus reset at all
  task t_freeze;
    begin
      CE = 1'b0;
      u_mst.bus_reset(pres);
      check({7'h00, pres}, 8'h00);
      CE = 1'b1;
      sp_expect({8'h7f, 8'h3c, 8'ha5, 8'hfe, 8'h6f});
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge CLK);
    #1 RST_B = 1'b1;
    t_power_up;
    t_resolution;
    t_identity;
    t_supply;
    t_convert;
    t_nvm;
    t_freeze;
    stop_test;
  end
  initial
  begin
    repeat (90000) @(posedge CLK);
    num_errors = num_errors + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test;
  end
endmodule // tb
